// *** shared/low_power_pkg.sv ***
/*
 * Shared constants and types of the low-power mode controller: register
 * offsets, field positions, reset values, delay defaults and carriers.
 * Assumes an 8-bit register port and a CPU core that reports its masks.
 */
package low_power_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h1;

	// Field positions inside the control register.
	localparam int DLY_BIT = 0;
	localparam int WDD_BIT = 1;
	localparam int ADC_BIT = 2;
	localparam int SPE_BIT = 3;
	localparam int TXE_BIT = 4;
	localparam int RXE_BIT = 5;

	// Control register after reset: only the restart delay is on.
	localparam logic [7:0] CTRL_RESET = 8'h01;

	// Size of the on-chip RAM that stop must retain.
	localparam int RAM_BYTES = 1024;

	// Default restart delay in oscillator cycles (plain default).
	localparam int RESTART_DELAY_DEF = 4064;

	// Control fields steered by software.
	typedef struct packed {
		logic       rx_enable;
		logic       tx_enable;
		logic       serial_periph_enable;
		logic       adc_power_up;
		logic       watchdog_disable;
		logic       restart_delay_enable;
	} ctrl_t;

	// Mask bits of the condition code register reported by the core.
	typedef struct packed {
		logic       stop_dis;
		logic       nmi_mask;
		logic       irq_mask;
	} condition_code_reg_t;

	// Clock and power gates driven toward the rest of the chip.
	typedef struct packed {
		logic       osc;
		logic       cpu;
		logic       timer;
		logic       adc;
		logic       spi;
		logic       sci_tx;
		logic       sci_rx;
	} gates_t;

	// Controller states.
	typedef enum logic [2:0] {
		ST_RUN,
		ST_STACK,
		ST_WAIT,
		ST_STOP,
		ST_DELAY
	} state_t;

	// What happens when a low-power condition ends.
	typedef enum logic [1:0] {
		CAUSE_RESUME,
		CAUSE_IRQ,
		CAUSE_NMI,
		CAUSE_RESET
	} cause_t;

endpackage : low_power_pkg

// *** design/low_power_mode_control.sv ***
/*
 * Low-power mode controller: wait and stop conditions, wake-up, restart
 * delay and peripheral clock gating, plus a small register file.
 * Assumes the CPU core pulses the opcode inputs, does the stacking when
 * asked and reports its masks; pins arrive synchronous to clk_sys.
 */
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module low_power_mode_control
	import low_power_pkg::*;
#(
	parameter int RESTART_DELAY = RESTART_DELAY_DEF
)
(
	// Clock and power-on reset.
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Register port.
	input  wire logic [3:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// CPU core side.
	input  wire logic                wait_opcode,
	input  wire logic                stop_opcode,
	input  condition_code_reg_t      condition_code_reg,
	input  wire logic [15:0]         ccr_stack_addr,
	input  wire logic                stack_done,
	input  wire logic                ccr_stacked,
	input  wire logic                periph_irq,
	output logic                     stack_req,
	output logic                     stop_nop,
	output logic                     resume,
	output logic                     irq_service,
	output logic                     nmi_service,
	output logic                     set_mask_x,
	output logic                     set_mask_i,
	output logic                     core_reset,
	// Idle bus cycles during wait.
	output logic                     bus_rd,
	output logic      [15:0]         bus_addr,
	// Pins.
	input  wire logic                irq_n,
	input  wire logic                irq_edge_pend,
	input  wire logic                nmi_req_n,
	input  wire logic                reset_pin_n,
	// Gates toward clocks, power, RAM and pads.
	output gates_t                   gates,
	output logic                     ram_hold,
	output logic                     io_hold
);

	// A zero delay would wrap the counter load to 65535.
	if (RESTART_DELAY < 1 || RESTART_DELAY > 65535)
	begin : g_bad_delay
		$error("RESTART_DELAY must lie between 1 and 65535");
	end

	localparam logic [15:0] DELAY_LOAD = 16'(RESTART_DELAY - 1);

	state_t      state_q, state_d;     // Controller state.
	cause_t      cause_q, cause_d;     // Why the condition ends.
	logic [15:0] cnt_q, cnt_d;         // Restart delay counter.
	logic [15:0] addr_q, addr_d;       // Stacked flags address.
	logic        nmi_pend_q, nmi_pend_d; // Nmi service in progress.
	logic        irq_pend_q, irq_pend_d; // Irq service in progress.
	logic [6:0]  pulse_q, pulse_d;     // Registered one-cycle outputs.
	ctrl_t       ctrl_q, ctrl_d;       // Software control bits.
	logic [7:0]  rdata_q, rdata_d;     // Read data, one cycle late.
	logic        wake_wait;            // Unmasked interrupt seen in wait.
	logic        wake_irq;             // Maskable wake from stop.

	// Decode of unmasked sources; both pins are active low.
	always_comb
	begin
		wake_wait = (~nmi_req_n & ~condition_code_reg.nmi_mask) |
		            ((~irq_n | periph_irq) &
		             ~condition_code_reg.irq_mask);
		wake_irq  = (~irq_n | irq_edge_pend) &
		            ~condition_code_reg.irq_mask;
	end

	// Next state of the sequencer and its one-cycle outputs.
	always_comb
	begin
		state_d    = state_q;
		cause_d    = cause_q;
		cnt_d      = cnt_q;
		addr_d     = addr_q;
		nmi_pend_d = nmi_pend_q;
		irq_pend_d = irq_pend_q;
		pulse_d    = 7'h00;
		// Bit order from the top: stop_nop, resume, set_x, set_i, nmi,
		// irq, spare.
		if (ccr_stacked && nmi_pend_q)
		begin
			// Both masks rise once the flags are on the stack.
			pulse_d[4] = 1'b1;
			pulse_d[3] = 1'b1;
			nmi_pend_d = 1'b0;
		end
		else if (ccr_stacked && irq_pend_q)
		begin
			// A maskable service only raises its own mask.
			pulse_d[3] = 1'b1;
			irq_pend_d = 1'b0;
		end
		case (state_q)
			ST_RUN:
			begin
				if (wait_opcode)
				begin
					// Stacking comes first so that wake-up is fast.
					addr_d  = ccr_stack_addr;
					state_d = ST_STACK;
				end
				else if (stop_opcode && condition_code_reg.stop_dis)
				begin
					pulse_d[6] = 1'b1;
				end
				else if (stop_opcode)
				begin
					state_d = ST_STOP;
				end
			end
			ST_STACK:
			begin
				// The core pushes its registers while we hold here.
				if (stack_done)
				begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (!reset_pin_n)
				begin
					state_d = ST_RUN;
				end
				else if (wake_wait)
				begin
					// Registers are already stacked, so go to service.
					state_d = ST_RUN;
					if (~nmi_req_n & ~condition_code_reg.nmi_mask)
					begin
						pulse_d[2] = 1'b1;
						nmi_pend_d = 1'b1;
					end
					else
					begin
						// The core is told to service the maskable request.
						pulse_d[1] = 1'b1;
						irq_pend_d = 1'b1;
					end
				end
			end
			ST_STOP:
			begin
				// Stop ends on a low pin level or a pending edge.
				if (!reset_pin_n)
				begin
					cause_d = CAUSE_RESET;
				end
				else if (!nmi_req_n)
				begin
					cause_d = condition_code_reg.nmi_mask ?
					          CAUSE_RESUME : CAUSE_NMI;
				end
				else if (wake_irq)
				begin
					cause_d = CAUSE_IRQ;
				end
				if (!reset_pin_n || !nmi_req_n || wake_irq)
				begin
					// A low reset pin always takes the delay, whatever the delay bit holds.
					cnt_d   = DELAY_LOAD;
					state_d = (ctrl_q.restart_delay_enable || !reset_pin_n)
					          ? ST_DELAY : ST_RUN;
				end
			end
			ST_DELAY:
			begin
				// Oscillator settles while the count runs down.
				if (cnt_q != 16'h0000)
				begin
					cnt_d = cnt_q - 16'h0001;
				end
				else
				begin
					state_d = ST_RUN;
				end
			end
			default:
			begin
				state_d = ST_RUN;
			end
		endcase
		// Leaving stop, directly or after the delay, tells the core how.
		if ((state_q == ST_STOP || state_q == ST_DELAY) &&
		    state_d == ST_RUN)
		begin
			case (cause_d)
				CAUSE_NMI:
				begin
					pulse_d[2] = 1'b1;
					nmi_pend_d = 1'b1;
				end
				CAUSE_IRQ:
				begin
					pulse_d[1]   = 1'b1;
					irq_pend_d   = 1'b1;
				end
				CAUSE_RESUME:
				begin
					pulse_d[5] = 1'b1;
				end
				default:
				begin
					pulse_d[0] = 1'b0;
				end
			endcase
		end
	end

	// Sequencer registers; power-on reset starts in the delay.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q    <= ST_DELAY;
			cause_q    <= CAUSE_RESET;
			cnt_q      <= DELAY_LOAD;
			addr_q     <= 16'h0000;
			nmi_pend_q <= 1'b0;
			irq_pend_q <= 1'b0;
			pulse_q    <= 7'h00;
		end
		else
		begin
			state_q    <= state_d;
			cause_q    <= cause_d;
			cnt_q      <= cnt_d;
			addr_q     <= addr_d;
			nmi_pend_q <= nmi_pend_d;
			irq_pend_q <= irq_pend_d;
			pulse_q    <= pulse_d;
		end
	end

	// Register file: writes, reset pin reload and read data.
	always_comb
	begin
		ctrl_d  = ctrl_q;
		rdata_d = 8'h00;
		if (reg_wr && reg_addr == CTRL_OFS)
		begin
			ctrl_d = ctrl_t'(reg_wdata[5:0]);
		end
		// The reset pin wins over a write in the same cycle.
		if (!reset_pin_n)
		begin
			ctrl_d = ctrl_t'(CTRL_RESET[5:0]);
		end
		if (reg_rd && reg_addr == CTRL_OFS)
		begin
			rdata_d = {2'b00, ctrl_q};
		end
		else if (reg_rd && reg_addr == STATUS_OFS)
		begin
			rdata_d = {1'b0, nmi_pend_q, cause_q, 1'b0, state_q};
		end
	end

	// Register file storage.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q  <= ctrl_t'(CTRL_RESET[5:0]);
			rdata_q <= 8'h00;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	// Gates and handshakes follow the registered state directly.
	always_comb
	begin
		gates.osc    = (state_q != ST_STOP);
		gates.cpu    = (state_q == ST_RUN) ||
		               (state_q == ST_STACK);
		gates.timer  = (state_q != ST_STOP) && (state_q != ST_DELAY) &&
		               !((state_q == ST_WAIT) &&
		                 condition_code_reg.irq_mask &&
		                 ctrl_q.watchdog_disable);
		gates.adc    = ctrl_q.adc_power_up && gates.osc;
		gates.spi    = ctrl_q.serial_periph_enable && gates.osc;
		gates.sci_tx = ctrl_q.tx_enable && gates.osc;
		gates.sci_rx = ctrl_q.rx_enable && gates.osc;
		// RAM clocks stop but its contents are never touched.
		ram_hold     = (state_q == ST_STOP);
		io_hold      = (state_q == ST_STOP) ||
		               ((state_q == ST_DELAY) &&
		                (cause_q != CAUSE_RESET));
		core_reset   = !reset_pin_n || ((state_q == ST_DELAY) &&
		               (cause_q == CAUSE_RESET));
		stack_req    = (state_q == ST_STACK);
		bus_rd       = (state_q == ST_WAIT);
		bus_addr     = addr_q;
		stop_nop     = pulse_q[6];
		resume       = pulse_q[5];
		irq_service  = pulse_q[1];
		nmi_service  = pulse_q[2];
		set_mask_x   = pulse_q[4];
		set_mask_i   = pulse_q[3];
		reg_rdata    = rdata_q;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_wait_stack;
		(state_q == ST_RUN) && wait_opcode |=> stack_req;
	endproperty
	a_wait_stack: assert property (p_wait_stack)
		else $error("wait opcode did not start stacking");

	property p_wait_exit;
		(state_q == ST_WAIT) && reset_pin_n && !nmi_req_n &&
		!condition_code_reg.nmi_mask |=>
		(state_q == ST_RUN) && nmi_service;
	endproperty
	a_wait_exit: assert property (p_wait_exit)
		else $error("unmasked nmi did not end wait");

	property p_wait_irq;
		(state_q == ST_WAIT) && reset_pin_n && nmi_req_n &&
		(!irq_n || periph_irq) && !condition_code_reg.irq_mask |=>
		(state_q == ST_RUN) && irq_service;
	endproperty
	a_wait_irq: assert property (p_wait_irq)
		else $error("unmasked maskable interrupt did not end wait");

	property p_wait_clk;
		(state_q == ST_WAIT) |-> gates.osc && !gates.cpu;
	endproperty
	a_wait_clk: assert property (p_wait_clk)
		else $error("wrong clocks in wait");

	property p_wait_read;
		(state_q == ST_WAIT) |-> bus_rd && (bus_addr == $past(bus_addr));
	endproperty
	a_wait_read: assert property (p_wait_read)
		else $error("idle read address moved in wait");

	property p_timer;
		(state_q == ST_WAIT) && !ctrl_q.watchdog_disable |-> gates.timer;
	endproperty
	a_timer: assert property (p_timer)
		else $error("timer halted with watchdog running");

	property p_stop_nop;
		(state_q == ST_RUN) && stop_opcode && !wait_opcode &&
		condition_code_reg.stop_dis |=> (state_q == ST_RUN) && stop_nop;
	endproperty
	a_stop_nop: assert property (p_stop_nop)
		else $error("disabled stop was not a no-operation");

	property p_stop_osc;
		(state_q == ST_STOP) |-> !gates.osc && !gates.timer && ram_hold;
	endproperty
	a_stop_osc: assert property (p_stop_osc)
		else $error("clock left running in stop");

	property p_delay_hold;
		(state_q == ST_DELAY) && (cnt_q != 16'h0000) |=>
		(state_q == ST_DELAY) && (cnt_q == $past(cnt_q) - 16'h0001);
	endproperty
	a_delay_hold: assert property (p_delay_hold)
		else $error("restart delay cut short");

	property p_dly_reset;
		!reset_pin_n |=> ctrl_q.restart_delay_enable;
	endproperty
	a_dly_reset: assert property (p_dly_reset)
		else $error("reset did not set delay bit");

	property p_nmi_masks;
		nmi_pend_q && ccr_stacked |=> set_mask_x && set_mask_i;
	endproperty
	a_nmi_masks: assert property (p_nmi_masks)
		else $error("nmi service did not set both masks");

endmodule : low_power_mode_control

// *** bench/core_model.sv ***
/*
 * Behavioural model of the CPU core beside the low-power controller.
 * Assumes the controller's clock and active-high reset.
 */
`timescale 1ns/1ns
module core_model
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rst,
	// Handshake with the controller.
	input  wire logic stack_req,
	input  wire logic nmi_service,
	input  wire logic irq_service,
	input  wire logic slow,
	output logic      stack_done,
	output logic      ccr_stacked
);
	int unsigned cnt_q; // Cycles spent stacking so far.
	int unsigned svc_q; // Countdown to the flags push of a service.

	// Slow stacking takes five cycles, so the request must be held.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 0;
			svc_q <= 0;
			stack_done <= 1'b0;
			ccr_stacked <= 1'b0;
		end
		else
		begin
			stack_done <= 1'b0;
			ccr_stacked <= (svc_q == 1);
			if (stack_req && !stack_done)
				cnt_q <= cnt_q + 1;
			if (stack_req && !stack_done && cnt_q >= (slow ? 4 : 0))
			begin
				stack_done <= 1'b1;
				cnt_q <= 0;
			end
			// Either service request leads to a flags push.
			if (nmi_service || irq_service)
				svc_q <= 3;
			else if (svc_q != 0)
				svc_q <= svc_q - 1;
		end
	end
endmodule : core_model

// *** bench/low_power_mode_control_tb.sv ***
/*
 * Self-checking bench of the low-power controller: register port,
 * wait and stop entry, every wake source and the restart delay.
 * Assumes the core model answers stacking requests.
 */
`timescale 1ns/1ns
module low_power_mode_control_tb
	import low_power_pkg::*;
;
	localparam int D = 4;         // Short restart delay keeps runs brief.
	localparam int LIMIT = 20000; // Cycle ceiling of the whole run.
	logic clk_sys, rst, reg_wr, reg_rd, wait_opcode, stop_opcode;
	logic stack_done, ccr_stacked, periph_irq, stack_req, stop_nop;
	logic resume, nmi_service, set_mask_x, set_mask_i, core_reset;
	logic bus_rd, irq_n, irq_edge_pend, nmi_req_n, reset_pin_n;
	logic ram_hold, io_hold, slow, irq_service;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, c, rd;
	logic [15:0] ccr_stack_addr, bus_addr, sa;
	condition_code_reg_t condition_code_reg;
	gates_t gates;
	int errors = 0, checked = 0, cyc = 0, n, nn, nr, mx, ni;
	int n_nmi = 0, n_res = 0, n_nop = 0, n_mx = 0, n_irq = 0;

	low_power_mode_control #(.RESTART_DELAY(D)) dut (
		.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .wait_opcode, .stop_opcode, .condition_code_reg,
		.ccr_stack_addr, .stack_done, .ccr_stacked, .periph_irq,
		.stack_req, .stop_nop, .resume, .irq_service, .nmi_service,
		.set_mask_x, .set_mask_i, .core_reset, .bus_rd, .bus_addr,
		.irq_n, .irq_edge_pend, .nmi_req_n, .reset_pin_n, .gates,
		.ram_hold, .io_hold);

	core_model partner (.clk_sys, .rst, .stack_req, .nmi_service,
		.irq_service, .slow, .stack_done, .ccr_stacked);

	// Clock gates expected in a settled state.
	function automatic gates_t exp_gates(input state_t s,
		input logic [7:0] cv, input logic im);
		gates_t g;
		g.osc = (s != ST_STOP);
		g.cpu = (s == ST_RUN);
		g.timer = g.cpu || (s == ST_WAIT && !(im && cv[WDD_BIT]));
		g.adc = g.osc && cv[ADC_BIT];
		g.spi = g.osc && cv[SPE_BIT];
		g.sci_tx = g.osc && cv[TXE_BIT];
		g.sci_rx = g.osc && cv[RXE_BIT];
		return g;
	endfunction : exp_gates

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe.
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	task automatic op(input logic is_stop);
		@(posedge clk_sys);
		stop_opcode <= is_stop;
		wait_opcode <= !is_stop;
		@(posedge clk_sys);
		stop_opcode <= 1'b0;
		wait_opcode <= 1'b0;
	endtask : op

	// Counts cycles until a flag drops, bounded.
	task automatic wait_low(ref logic f);
		n = 0;
		while (f !== 1'b0 && n < 50)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask : wait_low

	// Clock at 10 MHz.
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Pulse counters and the hang guard.
	always @(posedge clk_sys)
	begin
		n_nmi += (nmi_service === 1'b1);
		n_irq += (irq_service === 1'b1);
		n_res += (resume === 1'b1);
		n_nop += (stop_nop === 1'b1);
		n_mx += (set_mask_x === 1'b1 && set_mask_i === 1'b1);
		cyc++;
		if (cyc == LIMIT)
		begin
			errors++;
			report_and_stop();
		end
	end

	initial
	begin
		rst = 1'b1;
		{reg_wr, reg_rd, wait_opcode, stop_opcode, periph_irq} = '0;
		{irq_edge_pend, slow, reg_addr, reg_wdata} = '0;
		{irq_n, nmi_req_n, reset_pin_n} = 3'h7;
		condition_code_reg = 3'h3;
		ccr_stack_addr = 16'h0000;
		void'($urandom(28));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		wait_low(core_reset);
		check(n >= D && n <= D + 3, 1'b1);
		reg_read(CTRL_OFS, rd);
		check(rd, CTRL_RESET);
		// Read data stand one cycle only, then fall back to zero.
		@(posedge clk_sys);
		#1 check(reg_rdata, 8'h00);
		reg_read(4'hF, rd);
		check(rd, 8'h00);
		reg_write(STATUS_OFS, 8'hFF);
		reg_read(STATUS_OFS, rd);
		check(rd[2:0], ST_RUN);
		repeat (6)
		begin
			c = 8'($urandom);
			reg_write(CTRL_OFS, c);
			reg_read(CTRL_OFS, rd);
			check(rd, c & 8'h3F);
			check(gates, exp_gates(ST_RUN, c, 1'b1));
		end
		// A reset while clocks run reloads control to its reset value with no delay.
		@(posedge clk_sys);
		reset_pin_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_pin_n <= 1'b1;
		wait_low(core_reset);
		check(n <= 2, 1'b1);
		reg_read(CTRL_OFS, rd);
		check(rd, CTRL_RESET);
		// Stop with stop-disable set is a no-operation.
		nr = n_nop;
		@(posedge clk_sys);
		condition_code_reg <= 3'h7;
		op(1'b1);
		repeat (2) @(posedge clk_sys);
		#1 check(n_nop - nr, 1);
		check(gates.osc, 1'b1);
		// Wait: every irq mask and watchdog pairing, fast and slow core.
		for (int k = 0; k < 4; k++)
		begin
			c = {2'b00, 4'($urandom), k[1], 1'b1};
			sa = 16'($urandom);
			reg_write(CTRL_OFS, c);
			@(posedge clk_sys);
			condition_code_reg <= {2'b00, k[0]};
			ccr_stack_addr <= sa;
			slow <= k[0];
			op(1'b0);
			// Let the state register move into stacking before watching it.
			#1 wait_low(stack_req);
			#1 check(bus_rd, 1'b1);
			check(bus_addr, sa);
			check(gates, exp_gates(ST_WAIT, c, k[0]));
			nn = n_nmi;
			mx = n_mx;
			ni = n_irq;
			@(posedge clk_sys);
			if (k == 2)
				periph_irq <= 1'b1;
			else
				irq_n <= 1'b0;
			if (k[0])
			begin
				repeat (3) @(posedge clk_sys);
				#1 check(bus_rd, 1'b1);
				@(posedge clk_sys);
				irq_n <= 1'b1;
				nmi_req_n <= 1'b0;
			end
			wait_low(bus_rd);
			check(bus_rd, 1'b0);
			@(posedge clk_sys);
			{irq_n, nmi_req_n, periph_irq} <= 3'h6;
			repeat (8) @(posedge clk_sys);
			#1 check(n_nmi - nn, k[0]);
			check(n_mx - mx, k[0]);
			check(n_irq - ni, !k[0]);
		end
		// Stop: each wake source, with and without restart delay; reset only with it.
		for (int s = 0; s < 5; s++)
			for (int d = 0; d < 2; d++)
			begin
				if (s == 4 && d == 0)
					continue;
				reg_write(CTRL_OFS, {7'h00, d[0]});
				@(posedge clk_sys);
				condition_code_reg <= {1'b0, s == 0, 1'b1};
				op(1'b1);
				repeat (2) @(posedge clk_sys);
				#1 check(gates, exp_gates(ST_STOP, 8'h00, 1'b1));
				check({ram_hold, io_hold}, 2'b11);
				@(posedge clk_sys);
				irq_n <= 1'b0;
				repeat (3) @(posedge clk_sys);
				#1 check(gates.osc, 1'b0);
				@(posedge clk_sys);
				irq_n <= 1'b1;
				condition_code_reg.irq_mask <= (s < 2);
				nn = n_nmi;
				nr = n_res;
				ni = n_irq;
				@(posedge clk_sys);
				case (s)
					0, 1: nmi_req_n <= 1'b0;
					2: irq_n <= 1'b0;
					3: irq_edge_pend <= 1'b1;
					default: reset_pin_n <= 1'b0;
				endcase
				n = 0;
				do
				begin
					@(posedge clk_sys);
					if (n == 1)
						{irq_n, nmi_req_n, reset_pin_n, irq_edge_pend} <= 4'hE;
					#1 n++;
				end while ((s == 4 ? core_reset : io_hold) === 1'b1 && n < 50);
				@(posedge clk_sys);
				{irq_n, nmi_req_n, reset_pin_n, irq_edge_pend} <= 4'hE;
				check(d ? (n >= D && n <= D + 5) : (n <= 2), 1'b1);
				repeat (4) @(posedge clk_sys);
				#1 check(n_nmi - nn, s == 1);
				check(n_irq - ni, s == 2 || s == 3);
				if (s == 0)
					check(n_res - nr, 1);
				if (s == 4)
				begin
					reg_read(CTRL_OFS, rd);
					check(rd, CTRL_RESET);
					reg_read(STATUS_OFS, rd);
					check(rd, {2'b00, CAUSE_RESET, 1'b0, ST_RUN});
				end
			end
		report_and_stop();
	end
endmodule : low_power_mode_control_tb
